// [pkg/mpc_pkg.sv]
package mpc_pkg;
	// counter widths
	localparam int MPC_VAL_W = 20; // unsigned count, holds 999999
	localparam int MPC_SVAL_W = 21; // signed dual value and set value
	// full-scale limits
	localparam logic [19:0] MPC_MAX_SIX = 20'hF423F; // 999999
	localparam logic [19:0] MPC_MAX_FOUR = 20'h0270F; // 9999
	localparam logic [20:0] MPC_DUAL_MIN_SIX = 21'h1E7961; // -99999
	// register byte offsets
	localparam logic [7:0] MPC_OFF_CTRL = 8'h00;
	localparam logic [7:0] MPC_OFF_SET = 8'h04;
	localparam logic [7:0] MPC_OFF_SETB = 8'h08;
	localparam logic [7:0] MPC_OFF_PULSE = 8'h0C;
	localparam logic [7:0] MPC_OFF_RESTORE = 8'h10;
	localparam logic [7:0] MPC_OFF_PRESENT = 8'h14;
	localparam logic [7:0] MPC_OFF_CHB = 8'h18;
	localparam logic [7:0] MPC_OFF_TOTAL = 8'h1C;
	localparam logic [7:0] MPC_OFF_BATCH = 8'h20;
	localparam logic [7:0] MPC_OFF_DUAL = 8'h24;
	localparam logic [7:0] MPC_OFF_STATUS = 8'h28;
	// values after reset
	localparam logic [20:0] MPC_SET_RST = 21'h000000;
	localparam logic [15:0] MPC_PULSE_RST = 16'h03E8; // one-shot length in mclk cycles
	localparam logic [19:0] MPC_VAL_RST = 20'h00000;
	// synchroniser depth before edge detection
	localparam int MPC_SYNC_STAGES = 2;
	// configuration of the counting core
	typedef enum logic [2:0] {
		MPC_PRESET = 3'b000,
		MPC_TOTAL = 3'b001,
		MPC_BATCH = 3'b010,
		MPC_DUAL = 3'b011,
		MPC_TWIN = 3'b100
	} mpc_mode_t;
	typedef struct packed {
		logic dispSel; // which screen is shown: 0 first, 1 second
		logic oneShot; // 1: completion gives a timed pulse, 0: held output
		logic twoOutput; // model has two control outputs
		logic dualSub; // dual difference instead of sum
		logic sixDigit; // 1: six-digit ranges, 0: four-digit
		mpc_mode_t mode;
	} mpc_ctrl_t;
	localparam mpc_ctrl_t MPC_CTRL_RST = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, MPC_PRESET};
	// external pins, all asynchronous to mclk
	typedef struct packed {
		logic countInputA;
		logic countInputB;
		logic resetOne;
		logic resetTwo;
		logic resetKey;
	} mpc_pins_t;
endpackage

// [logic/mpc_counter_core.sv]
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// How it works
// R1 - two-output model drives both outputs together
// R2 - six-digit present value wraps at 999999
// R3 - primary reset blocks counting, clears present
// R4 - primary reset ends one-shot pulse immediately
// R5 - restored outputs return, one-shot replays fully
// R6 - set values clamped to digit range
// R7 - total keeps counting across present resets
// R8 - total reset clears only total count
// R9 - key on total screen clears all
// R10 - total count wraps at full scale
// R11 - batch increments per completion, output latched
// R12 - batch reset holds batch zero, off
// R13 - key on batch screen clears all
// R14 - batch set zero: count, never output
// R15 - batch count wraps at full scale
// R16 - lowering batch set below count sets output
// R17 - difference mode: A minus B, six-digit only
// R18 - dual reset clears, blocks own channel only
// R19 - key in dual mode clears everything; overflow stays set if the dual value was out of range at the press
// R20 - dual and channel ranges enforced
// R21 - overflow shows all-F and stops counting
// R22 - twin: independent counters, key clears shown
// R23 - sum mode adds both channels
// R24 - pins synchronised and edge-detected first
module mpc_counter_core
	import mpc_pkg::*;
#(
	parameter int PULSE_W = 16 // width of the one-shot length register
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire mpc_pins_t pins,
	output logic control_output_one,
	output logic control_output_two,
	output logic overflowOut
);
	initial begin
		if (PULSE_W < 1 || PULSE_W > 31) begin
			$error("PULSE_W out of range");
		end
	end

	// pin synchroniser chain plus one stage for edges
	logic [4:0] pinVec;
	logic [4:0] syncFirst;
	logic [4:0] syncSecond;
	logic [4:0] syncLast;
	logic [4:0] rise;
	assign pinVec = pins;
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			// first flop feeds only the second
			always_ff @(posedge mclk) begin
				if (rst) begin
					syncFirst[gi] <= 1'b0;
					syncSecond[gi] <= 1'b0;
					syncLast[gi] <= 1'b0;
				end else begin
					syncFirst[gi] <= pinVec[gi]; // R24
					syncSecond[gi] <= syncFirst[gi];
					syncLast[gi] <= syncSecond[gi];
				end
			end
			assign rise[gi] = syncSecond[gi] & ~syncLast[gi]; // R24
		end
	endgenerate

	// named views of the synchronised pins
	logic edgeA; // count pulse a
	logic edgeB; // count pulse b
	logic lvlResetOne; // primary reset level
	logic lvlResetTwo; // secondary reset level
	logic keyEdge; // front-panel key press
	assign edgeA = rise[4];
	assign edgeB = rise[3];
	assign lvlResetOne = syncSecond[2];
	assign lvlResetTwo = syncSecond[1];
	assign keyEdge = rise[0];

	// software-visible state
	mpc_ctrl_t ctrl;
	logic [20:0] setValue; // preset or dual set value, signed
	logic [19:0] setValueB; // batch set, or counter b set in twin
	logic [PULSE_W-1:0] pulseLen; // one-shot length
	logic [19:0] presentValue; // preset value, channel a in dual/twin
	logic [19:0] countB; // channel b
	logic [19:0] totalCount;
	logic [19:0] batchCount;
	logic batchOut;
	logic holdOn; // held completion output
	logic [PULSE_W-1:0] pulseTimer; // one-shot remaining cycles
	logic overflowFlag;
	logic dualMatchPrev;

	// derived configuration
	logic [19:0] maxValue;
	logic isDual;
	logic isTwin;
	logic subMode;
	assign maxValue = ctrl.sixDigit ? MPC_MAX_SIX : MPC_MAX_FOUR; // R6
	assign isDual = (ctrl.mode == MPC_DUAL);
	assign isTwin = (ctrl.mode == MPC_TWIN);
	assign subMode = ctrl.dualSub & ctrl.sixDigit; // R17

	// apb decode of the access phase
	logic apbAccess;
	logic apbWrite;
	assign apbAccess = psel & penable & pready;
	assign apbWrite = apbAccess & pwrite;

	// clamp a written set value into the legal range
	function automatic logic [20:0] clampSet(input logic [20:0] raw, input logic [19:0] lim,
		input logic allowNeg);
		logic [20:0] limS;
		limS = {1'b0, lim};
		if (raw[20]) begin
			if (!allowNeg) begin
				clampSet = 21'h000000;
			end else if ($signed(raw) < $signed(MPC_DUAL_MIN_SIX)) begin
				clampSet = MPC_DUAL_MIN_SIX;
			end else begin
				clampSet = raw;
			end
		end else if (raw > limS) begin
			clampSet = limS;
		end else begin
			clampSet = raw;
		end
	endfunction

	// clear and count decisions
	logic clrPresent; // present value / channel a clear
	logic clrChB; // channel b clear
	logic clrTotal;
	logic clrBatch;
	logic clrMain; // completion output clear
	logic incA;
	logic incB;
	always_comb begin
		clrPresent = lvlResetOne | (keyEdge & (!isTwin | !ctrl.dispSel)); // R3 R9 R13 R19 R22
		clrChB = (isDual | isTwin) & (lvlResetTwo | (keyEdge & (isDual | ctrl.dispSel))); // R18 R19 R22
		clrTotal = (ctrl.mode == MPC_TOTAL) & (lvlResetTwo | (keyEdge & ctrl.dispSel)); // R8 R9
		clrBatch = (ctrl.mode == MPC_BATCH) & (lvlResetTwo | (keyEdge & ctrl.dispSel)); // R12 R13
		clrMain = keyEdge | (lvlResetOne & !isDual & !isTwin); // R4
		// a key press voids a pulse in the same cycle, so no completion races a clear
		incA = edgeA & !lvlResetOne & !overflowFlag & !keyEdge; // R3 R21
		incB = edgeB & (isDual | isTwin) & !lvlResetTwo & !overflowFlag & !keyEdge; // R18 R21
	end

	// next preset value and completion
	logic [19:0] next_present;
	logic presetDone;
	always_comb begin
		if (presentValue >= maxValue) begin
			next_present = MPC_VAL_RST; // R2
		end else begin
			next_present = presentValue + 20'h00001;
		end
		presetDone = incA & !isDual & !isTwin & ({1'b0, next_present} == setValue);
	end

	// dual value; a cleared channel simply reads as zero
	logic [20:0] dualValue;
	logic dualDone;
	logic dualOver;
	always_comb begin
		if (subMode) begin
			dualValue = {1'b0, presentValue} - {1'b0, countB}; // R17
		end else begin
			dualValue = {1'b0, presentValue} + {1'b0, countB}; // R23
		end
		dualDone = isDual & (dualValue == setValue) & !dualMatchPrev;
		dualOver = ($signed(dualValue) > $signed({1'b0, maxValue})) // R20
			| (subMode & ($signed(dualValue) < $signed(MPC_DUAL_MIN_SIX)))
			| (incA & (presentValue >= maxValue)) | (incB & (countB >= maxValue));
	end

	// control registers written over apb
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl <= MPC_CTRL_RST;
			setValue <= MPC_SET_RST;
			setValueB <= MPC_VAL_RST;
			pulseLen <= PULSE_W'(MPC_PULSE_RST);
		end else if (apbWrite) begin
			if (paddr == MPC_OFF_CTRL) begin
				ctrl <= mpc_ctrl_t'(pwdata[7:0]);
			end else if (paddr == MPC_OFF_SET) begin
				setValue <= clampSet(pwdata[20:0], maxValue, isDual & ctrl.sixDigit); // R6
			end else if (paddr == MPC_OFF_SETB) begin
				setValueB <= 20'(clampSet(pwdata[20:0], maxValue, 1'b0)); // R6
			end else if (paddr == MPC_OFF_PULSE) begin
				pulseLen <= pwdata[PULSE_W-1:0];
			end
		end
	end

	// present value, also channel a in dual and twin modes
	always_ff @(posedge mclk) begin
		if (rst) begin
			presentValue <= MPC_VAL_RST;
		end else if (clrPresent) begin
			presentValue <= MPC_VAL_RST; // R3
		end else if (incA) begin
			if (isDual) begin
				// dual channels stop at full scale instead of wrapping
				presentValue <= (presentValue >= maxValue) ? presentValue : next_present; // R20
			end else begin
				presentValue <= next_present; // R2
			end
		end
	end

	// channel b counter for dual and twin
	always_ff @(posedge mclk) begin
		if (rst) begin
			countB <= MPC_VAL_RST;
		end else if (clrChB) begin
			countB <= MPC_VAL_RST; // R18
		end else if (incB) begin
			if (countB >= maxValue) begin
				countB <= isDual ? countB : MPC_VAL_RST; // R20 R22
			end else begin
				countB <= countB + 20'h00001; // R22
			end
		end
	end

	// total counter, unaffected by the primary reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			totalCount <= MPC_VAL_RST;
		end else if (clrTotal) begin
			totalCount <= MPC_VAL_RST; // R8
		end else if (edgeA & !overflowFlag & !keyEdge & (ctrl.mode == MPC_TOTAL)) begin // R7
			if (totalCount >= maxValue) begin
				totalCount <= MPC_VAL_RST; // R10
			end else begin
				totalCount <= totalCount + 20'h00001;
			end
		end
	end

	// batch counter, one step per preset completion
	always_ff @(posedge mclk) begin
		if (rst) begin
			batchCount <= MPC_VAL_RST;
		end else if (clrBatch) begin
			batchCount <= MPC_VAL_RST; // R12
		end else if (presetDone & (ctrl.mode == MPC_BATCH)) begin
			if (batchCount >= maxValue) begin
				batchCount <= MPC_VAL_RST; // R15
			end else begin
				batchCount <= batchCount + 20'h00001; // R11
			end
		end
	end

	// batch output latch; the reset level keeps it off as long as it is held
	always_ff @(posedge mclk) begin
		if (rst) begin
			batchOut <= 1'b0;
		end else if (clrBatch) begin
			batchOut <= 1'b0; // R12
		end else if (apbWrite & (paddr == MPC_OFF_RESTORE) & pwdata[1]) begin
			batchOut <= 1'b1; // R5
		end else if ((setValueB != MPC_VAL_RST) & (batchCount >= setValueB)) begin
			batchOut <= 1'b1; // R11 R14 R16
		end
	end

	// completion output: held latch or one-shot timer
	always_ff @(posedge mclk) begin
		if (rst) begin
			holdOn <= 1'b0;
			pulseTimer <= '0;
		end else if (clrMain) begin
			holdOn <= 1'b0;
			pulseTimer <= '0; // R4
		end else if (presetDone | dualDone
			| (apbWrite & (paddr == MPC_OFF_RESTORE) & pwdata[0])) begin
			if (ctrl.oneShot) begin
				pulseTimer <= pulseLen; // R5
			end else begin
				holdOn <= 1'b1; // R5
			end
		end else if (pulseTimer != '0) begin
			pulseTimer <= pulseTimer - PULSE_W'(1);
		end
	end

	// dual match edge tracking
	always_ff @(posedge mclk) begin
		if (rst) begin
			dualMatchPrev <= 1'b0;
		end else begin
			dualMatchPrev <= isDual & (dualValue == setValue);
		end
	end

	// overflow stops every counter until the key clears it
	always_ff @(posedge mclk) begin
		if (rst) begin
			overflowFlag <= 1'b0;
		end else if (isDual & dualOver) begin
			overflowFlag <= 1'b1; // R21
		end else if (keyEdge) begin
			overflowFlag <= 1'b0;
		end
	end

	// output mapping per configuration
	logic mainOn;
	logic twinA;
	logic twinB;
	logic next_outOne;
	logic next_outTwo;
	always_comb begin
		mainOn = holdOn | (pulseTimer != '0);
		twinA = (setValue[19:0] != MPC_VAL_RST) & (presentValue >= setValue[19:0]);
		twinB = (setValueB != MPC_VAL_RST) & (countB >= setValueB);
		case (ctrl.mode)
			MPC_BATCH: begin
				next_outOne = batchOut;
				next_outTwo = mainOn & ctrl.twoOutput;
			end
			MPC_TWIN: begin
				next_outOne = twinA & ctrl.twoOutput; // R22
				next_outTwo = twinB;
			end
			default: begin
				next_outOne = mainOn; // R1
				next_outTwo = mainOn & ctrl.twoOutput; // R1
			end
		endcase
	end

	// registered outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			control_output_one <= 1'b0;
			control_output_two <= 1'b0;
			overflowOut <= 1'b0;
		end else begin
			control_output_one <= next_outOne;
			control_output_two <= next_outTwo;
			overflowOut <= overflowFlag; // R21
		end
	end

	// read mux for the setup phase
	logic [31:0] next_rdata;
	logic next_err;
	always_comb begin
		next_rdata = 32'h00000000;
		next_err = 1'b0;
		if (paddr == MPC_OFF_CTRL) begin
			next_rdata = {24'h000000, ctrl};
		end else if (paddr == MPC_OFF_SET) begin
			next_rdata = {{11{setValue[20]}}, setValue};
		end else if (paddr == MPC_OFF_SETB) begin
			next_rdata = {12'h000, setValueB};
		end else if (paddr == MPC_OFF_PULSE) begin
			next_rdata = 32'(pulseLen);
		end else if (paddr == MPC_OFF_RESTORE) begin
			next_rdata = 32'h00000000;
		end else if (paddr == MPC_OFF_PRESENT) begin
			next_rdata = overflowFlag ? 32'h00FFFFFF : {12'h000, presentValue}; // R21
		end else if (paddr == MPC_OFF_CHB) begin
			next_rdata = overflowFlag ? 32'h00FFFFFF : {12'h000, countB};
		end else if (paddr == MPC_OFF_TOTAL) begin
			next_rdata = {12'h000, totalCount};
		end else if (paddr == MPC_OFF_BATCH) begin
			next_rdata = {12'h000, batchCount};
		end else if (paddr == MPC_OFF_DUAL) begin
			next_rdata = overflowFlag ? 32'h00FFFFFF : {{11{dualValue[20]}}, dualValue};
		end else if (paddr == MPC_OFF_STATUS) begin
			next_rdata = {27'h0000000, overflowFlag, batchOut, mainOn, control_output_two,
				control_output_one};
		end else begin
			next_err = 1'b1; // unmapped address
		end
	end

	// apb slave: one wait-free access phase, answer registered in setup
	always_ff @(posedge mclk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & !penable;
			if (psel & !penable) begin
				prdata <= pwrite ? 32'h00000000 : next_rdata;
				pslverr <= next_err;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end
endmodule

// [tb/mpc_counter_core_properties.sv]
`timescale 1ns/1ps
module mpc_counter_core_properties
	import mpc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire mpc_pins_t pins,
	input wire logic control_output_one,
	input wire logic control_output_two,
	input wire logic overflowOut
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [7:0] ctl; // shadow of the control word
	wire mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h28); // decoded window
	// shadow follows completed control writes only
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl <= 8'h28;
		end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
			ctl <= pwdata[7:0];
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	// six cycles covers sync, completion clear and output register
	sequence s_holdOne;
		pins.resetOne [*6];
	endsequence
	property p_access;
		s_setup |=> pready;
	endproperty
	property p_readyOnce;
		pready |=> !pready;
	endproperty
	property p_readyCause;
		pready |-> psel && penable && $past(psel);
	endproperty
	property p_mapped;
		pready && mapped |-> !pslverr;
	endproperty
	property p_unmapped;
		pready && !mapped |-> pslverr && prdata == 32'h0;
	endproperty
	property p_quiet;
		$fell(rst) |-> !control_output_one && !control_output_two && !pready && !overflowOut;
	endproperty
	property p_together;
		ctl[5] && (ctl[2:0] == 3'h0 || ctl[2:0] == 3'h1 || ctl[2:0] == 3'h3) && $stable(ctl)
			|-> control_output_one == control_output_two;
	endproperty
	property p_resetOff;
		s_holdOne |-> ctl[2:0] >= 3'h3
			|| !(ctl[2:0] == 3'h2 ? control_output_two : control_output_one);
	endproperty
	property p_ovfDual;
		overflowOut |-> ctl[2:0] == 3'h3;
	endproperty
	a_access: assert property (p_access) else $error("setup not answered");
	a_readyOnce: assert property (p_readyOnce) else $error("ready held too long");
	a_readyCause: assert property (p_readyCause) else $error("ready without access");
	a_mapped: assert property (p_mapped) else $error("error on mapped word");
	a_unmapped: assert property (p_unmapped) else $error("unmapped word accepted");
	a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
	a_together: assert property (p_together) else $error("outputs split");
	a_resetOff: assert property (p_resetOff) else $error("output kept in reset");
	a_ovfDual: assert property (p_ovfDual) else $error("overflow outside dual");
endmodule
bind mpc_counter_core mpc_counter_core_properties u_props (.mclk(mclk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pins(pins), .control_output_one(control_output_one),
	.control_output_two(control_output_two), .overflowOut(overflowOut));

// [tb/mpc_pulse_source.sv]
`timescale 1ns/1ps
module mpc_pulse_source
	import mpc_pkg::*;
(
	input wire logic mclk,
	output mpc_pins_t pins
);
	initial pins = '0; // contacts open at power-up
	// clean pulses, wider than two cycles both ways
	task automatic pulse(input int i, input int n);
		repeat (n) begin
			@(posedge mclk);
			pins[i] <= 1'b1;
			repeat (3) @(posedge mclk);
			pins[i] <= 1'b0;
			repeat (4) @(posedge mclk);
		end
	endtask
	// held level, then time for it to settle inside
	task automatic level(input int i, input logic v);
		@(posedge mclk);
		pins[i] <= v;
		repeat (6) @(posedge mclk);
	endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import mpc_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdv;
	logic pready, pslverr, outOne, outTwo, ovf, rerr;
	wire mpc_pins_t pins;
	int mismatches = 0;
	int cmp_count = 0;
	int lfsr = 28696; // random source
	int pa, tot, bat, na, nb; // reference counts
	initial begin
		forever #25 mclk = ~mclk;
	end
	mpc_counter_core dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .control_output_one(outOne),
		.control_output_two(outTwo), .overflowOut(ovf));
	mpc_pulse_source src (.mclk(mclk), .pins(pins));
	function automatic int nxt(input int v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one transfer, held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		@(posedge mclk);
		while (pready !== 1'b1 && k < 16) begin
			k++;
			@(posedge mclk);
		end
		if (k == 16) mismatches++;
		rdv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rdv, e);
	endtask
	task automatic results();
		$display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// hang guard, far beyond the expected run
	initial begin
		#3000000;
		mismatches++;
		results();
	end
	// pins: 4 count a, 3 count b, 2 reset one, 1 reset two, 0 key
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd(MPC_OFF_CTRL, 32'h00000028);
		rd(MPC_OFF_PULSE, 32'h000003E8);
		rd(MPC_OFF_PRESENT, 32'h0);
		apb(1'b0, 8'h2C, 32'h0);
		check(rerr, 32'h1);
		wr(MPC_OFF_SET, 32'h000FFFFF);
		rd(MPC_OFF_SET, 32'h000F423F);
		wr(MPC_OFF_CTRL, 32'h20);
		wr(MPC_OFF_SET, 32'h000FFFFF);
		rd(MPC_OFF_SET, 32'h0000270F);
		wr(MPC_OFF_SET, 32'h001FFFFF);
		rd(MPC_OFF_SET, 32'h0);
		// total and preset
		wr(MPC_OFF_CTRL, 32'h29);
		wr(MPC_OFF_SET, 32'h3);
		src.pulse(4, 3);
		pa = 3;
		tot = 3;
		check({outOne, outTwo}, 32'h3);
		src.level(2, 1'b1);
		src.pulse(4, 2);
		tot += 2;
		rd(MPC_OFF_PRESENT, 32'h0);
		check(outOne, 32'h0);
		src.level(2, 1'b0);
		rd(MPC_OFF_TOTAL, tot);
		src.pulse(4, 3);
		src.level(1, 1'b1);
		rd(MPC_OFF_TOTAL, 32'h0);
		rd(MPC_OFF_PRESENT, pa);
		src.level(1, 1'b0);
		wr(MPC_OFF_CTRL, 32'hA9);
		src.pulse(0, 1);
		rd(MPC_OFF_PRESENT, 32'h0);
		rd(MPC_OFF_TOTAL, 32'h0);
		check(outOne, 32'h0);
		// batch: each completion ends with a primary reset
		wr(MPC_OFF_CTRL, 32'h2A);
		wr(MPC_OFF_SET, 32'h1);
		wr(MPC_OFF_SETB, 32'h2);
		bat = 0;
		repeat (2) begin
			src.pulse(4, 1);
			src.level(2, 1'b1);
			src.level(2, 1'b0);
			bat++;
		end
		rd(MPC_OFF_BATCH, bat);
		apb(1'b0, MPC_OFF_STATUS, 32'h0);
		check(rdv[3], 32'h1);
		src.level(1, 1'b1);
		rd(MPC_OFF_BATCH, 32'h0);
		apb(1'b0, MPC_OFF_STATUS, 32'h0);
		check(rdv[3], 32'h0);
		src.level(1, 1'b0);
		wr(MPC_OFF_SETB, 32'h0);
		src.pulse(4, 1);
		src.level(2, 1'b1);
		src.level(2, 1'b0);
		rd(MPC_OFF_BATCH, 32'h1);
		apb(1'b0, MPC_OFF_STATUS, 32'h0);
		check(rdv[3], 32'h0);
		wr(MPC_OFF_SETB, 32'h5);
		repeat (2) begin
			src.pulse(4, 1);
			src.level(2, 1'b1);
			src.level(2, 1'b0);
		end
		wr(MPC_OFF_SETB, 32'h1);
		wr(MPC_OFF_SETB, 32'h5);
		apb(1'b0, MPC_OFF_STATUS, 32'h0);
		check(rdv[3], 32'h1);
		// dual with random channel counts
		lfsr = nxt(lfsr);
		na = 1 + lfsr % 4;
		lfsr = nxt(lfsr);
		nb = 1 + lfsr % 4;
		wr(MPC_OFF_CTRL, 32'h2B);
		wr(MPC_OFF_SET, 32'h000F423F);
		src.pulse(0, 1);
		src.pulse(4, na);
		src.pulse(3, nb);
		rd(MPC_OFF_DUAL, na + nb);
		rd(MPC_OFF_CHB, nb);
		check(ovf, 32'h0);
		wr(MPC_OFF_CTRL, 32'h3B);
		src.pulse(0, 1);
		rd(MPC_OFF_DUAL, 32'h0);
		src.pulse(4, na);
		src.pulse(3, nb);
		rd(MPC_OFF_DUAL, na - nb);
		src.level(2, 1'b1);
		src.pulse(4, 1);
		rd(MPC_OFF_DUAL, -nb);
		src.level(2, 1'b0);
		// twin: the key clears only the counter on show
		wr(MPC_OFF_CTRL, 32'hAC);
		src.pulse(0, 1);
		wr(MPC_OFF_SET, 32'h2);
		wr(MPC_OFF_SETB, 32'h1);
		src.pulse(4, 2);
		src.pulse(3, 1);
		check({outOne, outTwo}, 32'h3);
		src.pulse(0, 1);
		rd(MPC_OFF_CHB, 32'h0);
		rd(MPC_OFF_PRESENT, 32'h2);
		check({outOne, outTwo}, 32'h2);
		// one-shot ended by reset, replayed on restore
		wr(MPC_OFF_CTRL, 32'h68);
		src.pulse(0, 1);
		wr(MPC_OFF_PULSE, 32'h28);
		wr(MPC_OFF_SET, 32'h1);
		src.pulse(4, 1);
		check({outOne, outTwo}, 32'h3);
		src.level(2, 1'b1);
		check(outOne, 32'h0);
		src.level(2, 1'b0);
		wr(MPC_OFF_RESTORE, 32'h1);
		repeat (3) @(posedge mclk);
		check(outOne, 32'h1);
		// look just after the edges so the last high and first low cycle are exact
		repeat (37) @(posedge mclk);
		#1;
		check(outOne, 32'h1);
		@(posedge mclk);
		#1;
		check(outOne, 32'h0);
		results();
	end
endmodule
